// *** cip_pkg.sv ***
/*
  cip_pkg: shared constants and carrier types of the charger input
  protection control logic.
  Assumes a single 125 MHz system clock; all times are converted to
  whole clock cycles here, rounding least times up.
*/
package cip_pkg;

  //////////////////////////////////////////////////////////////////////
  // clock and time base
  localparam int CIP_CLK_PERIOD_NS = 8;

  // least times in ns, plain defaults for parts that are not printed
  localparam int CIP_OVP_BLANK_NS = 1000;
  localparam int CIP_OVP_RESTART_NS = 8000;
  localparam int CIP_OCP_BLANK_NS = 5000;
  localparam int CIP_OCP_REC_NS = 64000;
  localparam int CIP_PGOOD_NS = 8000;
  localparam int CIP_SOFT_START_NS = 1000;
  localparam int CIP_SOFT_STOP_NS = 1000;

  // round a least time up to whole cycles, never below one
  function automatic int cip_cyc(input int ns);
    int c;
    c = (ns + CIP_CLK_PERIOD_NS - 1) / CIP_CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int CIP_OVP_BLANK_CYC = cip_cyc(CIP_OVP_BLANK_NS);
  localparam int CIP_OVP_RESTART_CYC = cip_cyc(CIP_OVP_RESTART_NS);
  localparam int CIP_OCP_BLANK_CYC = cip_cyc(CIP_OCP_BLANK_NS);
  localparam int CIP_OCP_REC_CYC = cip_cyc(CIP_OCP_REC_NS);
  localparam int CIP_PGOOD_CYC = cip_cyc(CIP_PGOOD_NS);
  localparam int CIP_SOFT_START_CYC = cip_cyc(CIP_SOFT_START_NS);
  localparam int CIP_SOFT_STOP_CYC = cip_cyc(CIP_SOFT_STOP_NS);

  //////////////////////////////////////////////////////////////////////
  // widths and limits
  localparam int CIP_TMR_W = 16;
  localparam int CIP_CNT_W = 4;
  localparam int CIP_FAULT_LIMIT = 15;
  // battery comparator trip point, fixed inside the analog front end
  localparam int CIP_BATTERY_OVERVOLTAGE_GUARD_THRESHOLD_MV = 4350;

  //////////////////////////////////////////////////////////////////////
  // comparator outputs from the analog front end
  typedef struct packed {
    logic in_ov;     // input above input_overvoltage_threshold
    logic in_oc;     // load current at overcurrent_threshold
    logic bat_ov;    // battery above battery_overvoltage_threshold
    logic bat_ok;    // battery below threshold minus hysteresis
    logic die_hot;   // die above thermal_shutdown_level
    logic die_cool;  // die below level minus thermal_shutdown_hysteresis
  } cip_sense_s;

  // commands to the analog pass_switch driver
  typedef struct packed {
    logic pass_on;     // pass_switch gate enabled
    logic soft_start;  // ramp gate up
    logic soft_stop;   // ramp gate down instead of cutting it
    logic out_clamp;   // hold output at regulated_output_level
    logic cur_limit;   // hold current at the limit
  } cip_drive_s;

  typedef enum logic [3:0] {
    CIP_ST_DEGLITCH,
    CIP_ST_ON,
    CIP_ST_OVP_BLANK,
    CIP_ST_OVP_OFF,
    CIP_ST_OVP_RESTART,
    CIP_ST_OCP_BLANK,
    CIP_ST_OCP_REC,
    CIP_ST_BAT_OFF,
    CIP_ST_HOT_OFF,
    CIP_ST_LATCHED,
    CIP_ST_DISABLED
  } cip_state_e;

endpackage

// *** cip_sync.sv ***
/*
  cip_sync: two flip-flop synchroniser for a bundle of levels.
  Assumes the inputs are slow levels; no bus coherence is promised.
*/
`timescale 1ns/1ps
module cip_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;

  if (WIDTH < 1) begin : g_bad_width
    $error("cip_sync width must be at least one");
  end

  // first stage feeds only the second one
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end

endmodule // cip_sync

// *** cip_guard_fsm.sv ***
/*
  cip_guard_fsm: protection state machine of a charger input guard.
  Decides when the pass_switch is on, off or latched off, and drives
  the active-low open-drain fault pin.
  Assumes comparators already apply their own hysteresis, rst is the
  undervoltage_lockout power-on reset, and the pad of enable_n has a
  pull-down so a floating pin arrives here as 0.
*/
//
// Function
// R1: input overvoltage clamps output, starts blanking
// R2: overvoltage gone before blanking ends, resume
// R3: overvoltage past blanking opens pass switch
// R4: safe input, restart delay, soft-start on
// R5: overcurrent limits current, starts blanking
// R6: overcurrent gone before blanking ends, resume
// R7: overcurrent past blanking: off, fault, recover
// R8: after recovery, switch on, blanking anew
// R9: count overcurrent trips, latch off at 15
// R10: enable toggle clears counters and latch
// R11: overcurrent shutdown uses soft-stop ramp
// R12: battery overvoltage opens switch, fault low
// R13: battery below hysteresis point, switch on
// R14: count battery trips, latch off at 15
// R15: battery overvoltage shutdown uses soft-stop
// R16: overtemperature opens switch until cooled
// R17: enable pin high forces switch off
// R18: enabled, on only when nothing unsafe
// R19: floating enable pin reads as enabled
// R20: fault released when disabled or safe
// R21: fault low whenever protection opens switch
// R22: below lockout: switch off, fault released
// R23: power-up resets, deglitch, then checks
// R24: overvoltage at deglitch end: never on
// R25: synced inputs, cycle-count timing parameters
`timescale 1ns/1ps
module cip_guard_fsm
  import cip_pkg::*;
#(
  parameter int TMR_W = CIP_TMR_W,
  parameter int OVP_BLANK_CYC = CIP_OVP_BLANK_CYC,
  parameter int OVP_RESTART_CYC = CIP_OVP_RESTART_CYC,
  parameter int OCP_BLANK_CYC = CIP_OCP_BLANK_CYC,
  parameter int OCP_REC_CYC = CIP_OCP_REC_CYC,
  parameter int PGOOD_CYC = CIP_PGOOD_CYC,
  parameter int SOFT_START_CYC = CIP_SOFT_START_CYC,
  parameter int SOFT_STOP_CYC = CIP_SOFT_STOP_CYC,
  parameter int FAULT_LIMIT = CIP_FAULT_LIMIT
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic enable_n,
  input wire cip_sense_s sense,
  output cip_drive_s drive,
  output logic fault_out,
  output logic fault_oe_n,
  output logic latched_off
);

  //////////////////////////////////////////////////////////////////////
  // elaboration checks
  localparam int TMR_MAX = (1 << TMR_W) - 1;

  if (TMR_W < 2 || TMR_W > 30) begin : g_bad_tmr_w
    $error("timer width out of range");
  end
  if (OVP_BLANK_CYC < 1 || OVP_BLANK_CYC > TMR_MAX ||
      OVP_RESTART_CYC < 1 || OVP_RESTART_CYC > TMR_MAX ||
      OCP_BLANK_CYC < 1 || OCP_BLANK_CYC > TMR_MAX ||
      OCP_REC_CYC < 1 || OCP_REC_CYC > TMR_MAX ||
      PGOOD_CYC < 1 || PGOOD_CYC > TMR_MAX ||
      SOFT_START_CYC < 1 || SOFT_START_CYC > TMR_MAX ||
      SOFT_STOP_CYC < 1 || SOFT_STOP_CYC > TMR_MAX) begin : g_bad_cyc
    $error("a cycle count does not fit the timer");
  end
  if (FAULT_LIMIT < 1 || FAULT_LIMIT > (1 << CIP_CNT_W) - 1) begin : g_bad_lim
    $error("fault limit does not fit the counter");
  end

  // load value for a down-counter that expires after cyc cycles
  function automatic logic [TMR_W-1:0] tmr_load(input int cyc);
    return TMR_W'(cyc - 1);
  endfunction

  localparam logic [CIP_CNT_W-1:0] CNT_LAST = CIP_CNT_W'(FAULT_LIMIT - 1);

  //////////////////////////////////////////////////////////////////////
  // input synchronisers
  localparam int SYNC_W = $bits(cip_sense_s) + 1;

  logic [SYNC_W-1:0] sync_out;
  cip_sense_s s;
  logic en;

  // R25 synchronise comparators
  cip_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .din({sense, enable_n}),
    .dout(sync_out)
  );

  // R19 low or floating enables
  assign s = sync_out[SYNC_W-1:1];
  assign en = ~sync_out[0];

  //////////////////////////////////////////////////////////////////////
  // state, timers and counters
  cip_state_e state, next_state;
  logic [TMR_W-1:0] tmr, next_tmr;
  logic [TMR_W-1:0] ramp, next_ramp;
  logic ramp_down, next_ramp_down;
  logic [CIP_CNT_W-1:0] ocp_cnt, next_ocp_cnt;
  logic [CIP_CNT_W-1:0] bat_cnt, next_bat_cnt;
  cip_drive_s next_drive;
  logic next_fault;
  logic tmr_done;
  logic soft_off;
  logic hard_off;
  cip_state_e resume;

  assign tmr_done = (tmr == '0);

  // where to go when switching on is asked for: on only if all safe
  always_comb begin
    resume = CIP_ST_ON;
    // R18 on only when safe
    if (s.die_hot) begin
      resume = CIP_ST_HOT_OFF;
    end else if (s.in_ov) begin
      resume = CIP_ST_OVP_OFF;
    end else if (s.bat_ov) begin
      resume = CIP_ST_BAT_OFF;
    end
  end

  // next state; thermal beats overvoltage beats battery beats current
  always_comb begin
    next_state = state;
    next_tmr = tmr;
    next_ocp_cnt = ocp_cnt;
    next_bat_cnt = bat_cnt;
    soft_off = 1'b0;
    hard_off = 1'b0;
    if (!en && state != CIP_ST_DEGLITCH) begin
      // R17 disable forces off
      next_state = CIP_ST_DISABLED;
      hard_off = 1'b1;
    end else if (s.die_hot && state != CIP_ST_DEGLITCH &&
                 state != CIP_ST_HOT_OFF && state != CIP_ST_LATCHED &&
                 state != CIP_ST_DISABLED) begin
      // R16 overtemperature opens
      next_state = CIP_ST_HOT_OFF;
      hard_off = 1'b1;
    end else begin
      unique case (state)
        CIP_ST_DEGLITCH: begin
          // R23 wait power-good deglitch
          if (tmr_done) begin
            // R24 overvoltage blocks turn-on
            next_state = en ? resume : CIP_ST_DISABLED;
          end else begin
            next_tmr = tmr - 1'b1;
          end
        end
        CIP_ST_ON: begin
          if (s.in_ov) begin
            // R1 clamp and blank
            next_state = CIP_ST_OVP_BLANK;
            next_tmr = tmr_load(OVP_BLANK_CYC);
          end else if (s.bat_ov) begin
            // R12 battery overvoltage off
            soft_off = 1'b1;
            next_bat_cnt = bat_cnt + 1'b1;
            // R14 latch at limit
            next_state = (bat_cnt == CNT_LAST) ? CIP_ST_LATCHED : CIP_ST_BAT_OFF;
          end else if (s.in_oc) begin
            // R5 limit and blank
            next_state = CIP_ST_OCP_BLANK;
            next_tmr = tmr_load(OCP_BLANK_CYC);
          end
        end
        CIP_ST_OVP_BLANK: begin
          if (!s.in_ov) begin
            // R2 transient, no fault
            next_state = CIP_ST_ON;
          end else if (tmr_done) begin
            // R3 persistent, open switch
            next_state = CIP_ST_OVP_OFF;
            hard_off = 1'b1;
          end else begin
            next_tmr = tmr - 1'b1;
          end
        end
        CIP_ST_OVP_OFF: begin
          if (!s.in_ov) begin
            // R4 start restart delay
            next_state = CIP_ST_OVP_RESTART;
            next_tmr = tmr_load(OVP_RESTART_CYC);
          end
        end
        CIP_ST_OVP_RESTART: begin
          if (s.in_ov) begin
            next_state = CIP_ST_OVP_OFF;
          end else if (tmr_done) begin
            // R4 delay over, switch on
            next_state = resume;
          end else begin
            next_tmr = tmr - 1'b1;
          end
        end
        CIP_ST_OCP_BLANK: begin
          if (s.in_ov) begin
            next_state = CIP_ST_OVP_BLANK;
            next_tmr = tmr_load(OVP_BLANK_CYC);
          end else if (s.bat_ov) begin
            soft_off = 1'b1;
            next_bat_cnt = bat_cnt + 1'b1;
            next_state = (bat_cnt == CNT_LAST) ? CIP_ST_LATCHED : CIP_ST_BAT_OFF;
          end else if (!s.in_oc) begin
            // R6 brief overload, resume
            next_state = CIP_ST_ON;
          end else if (tmr_done) begin
            // R7 persistent, off with soft-stop
            soft_off = 1'b1;
            next_ocp_cnt = ocp_cnt + 1'b1;
            next_tmr = tmr_load(OCP_REC_CYC);
            // R9 latch at limit
            next_state = (ocp_cnt == CNT_LAST) ? CIP_ST_LATCHED : CIP_ST_OCP_REC;
          end else begin
            next_tmr = tmr - 1'b1;
          end
        end
        CIP_ST_OCP_REC: begin
          if (tmr_done) begin
            // R8 back on, blanking anew
            next_state = resume;
          end else begin
            next_tmr = tmr - 1'b1;
          end
        end
        CIP_ST_BAT_OFF: begin
          // R13 reclose below hysteresis
          if (s.bat_ok) begin
            next_state = resume;
          end
        end
        CIP_ST_HOT_OFF: begin
          // R16 reclose once cooled
          if (s.die_cool && !s.die_hot) begin
            next_state = resume;
          end
        end
        CIP_ST_LATCHED: begin
          // only the enable toggle leaves here
          next_state = CIP_ST_LATCHED;
        end
        CIP_ST_DISABLED: begin
          // R10 toggle clears counters
          next_ocp_cnt = '0;
          next_bat_cnt = '0;
          next_state = resume;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // gate ramp: soft-start on every turn-on, soft-stop on current and
  // battery trips; overvoltage and heat cut at once since waiting
  // would pass the hazard downstream
  always_comb begin
    next_ramp = ramp;
    next_ramp_down = ramp_down;
    if (next_state == CIP_ST_ON && state != CIP_ST_ON &&
        state != CIP_ST_OVP_BLANK && state != CIP_ST_OCP_BLANK) begin
      // R4 soft-start on turn-on
      next_ramp = tmr_load(SOFT_START_CYC);
      next_ramp_down = 1'b0;
    end else if (soft_off) begin
      // R11 R15 ramped turn-off
      next_ramp = tmr_load(SOFT_STOP_CYC);
      next_ramp_down = 1'b1;
    end else if (hard_off) begin
      next_ramp = '0;
      next_ramp_down = 1'b0;
    end else if (ramp != '0) begin
      next_ramp = ramp - 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // output decode from next values, so outputs come from flip-flops
  always_comb begin
    next_drive = '0;
    next_drive.pass_on = (next_state == CIP_ST_ON) ||
                         (next_state == CIP_ST_OVP_BLANK) ||
                         (next_state == CIP_ST_OCP_BLANK);
    next_drive.soft_start = next_drive.pass_on && !next_ramp_down &&
                            (next_ramp != '0 || soft_start_edge(next_state, state));
    next_drive.soft_stop = !next_drive.pass_on && next_ramp_down;
    // R1 clamp during blanking
    next_drive.out_clamp = (next_state == CIP_ST_OVP_BLANK);
    // R5 limit during blanking
    next_drive.cur_limit = (next_state == CIP_ST_OCP_BLANK);
    // R20 R21 fault only on protective off
    next_fault = (next_state == CIP_ST_OVP_OFF) ||
                 (next_state == CIP_ST_OVP_RESTART) ||
                 (next_state == CIP_ST_OCP_REC) ||
                 (next_state == CIP_ST_BAT_OFF) ||
                 (next_state == CIP_ST_HOT_OFF) ||
                 (next_state == CIP_ST_LATCHED);
  end

  // true on the cycle the switch is first asked to close
  function automatic logic soft_start_edge(input cip_state_e nxt,
                                           input cip_state_e cur);
    return (nxt == CIP_ST_ON) && (cur != CIP_ST_ON) &&
           (cur != CIP_ST_OVP_BLANK) && (cur != CIP_ST_OCP_BLANK);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // registers; reset is the lockout release
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      // R22 R23 lockout: off, cleared
      state <= CIP_ST_DEGLITCH;
      tmr <= tmr_load(PGOOD_CYC);
      ramp <= '0;
      ramp_down <= 1'b0;
      ocp_cnt <= '0;
      bat_cnt <= '0;
      drive <= '0;
      fault_oe_n <= 1'b1;
      latched_off <= 1'b0;
    end else begin
      state <= next_state;
      tmr <= next_tmr;
      ramp <= next_ramp;
      ramp_down <= next_ramp_down;
      ocp_cnt <= next_ocp_cnt;
      bat_cnt <= next_bat_cnt;
      drive <= next_drive;
      fault_oe_n <= ~next_fault;
      latched_off <= (next_state == CIP_ST_LATCHED);
    end
  end

  // open drain: the pin is only ever pulled low
  assign fault_out = 1'b0;

endmodule // cip_guard_fsm

// *** cip_guard_fsm_assertions.sv ***
/*
  cip_guard_fsm_assertions: pin-level timing checks of the guard.
  Assumes it is bound into cip_guard_fsm with its blanking count.
*/
`timescale 1ns/1ps
module cip_guard_fsm_assertions
  import cip_pkg::*;
#(
  parameter int OCP_BLANK_CYC = CIP_OCP_BLANK_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic enable_n,
  input wire cip_sense_s sense,
  input wire cip_drive_s drive,
  input wire logic fault_out,
  input wire logic fault_oe_n,
  input wire logic latched_off
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic [3:0] en_run;
  logic [3:0] next_en_run;
  logic [15:0] lim_run;
  logic [15:0] next_lim_run;

  //////////////////////////////////////////////////////////////////////
  // run lengths: enable held low (saturates) and current limiting
  always_comb begin
    next_en_run = enable_n ? 4'h0 : (en_run == 4'hf ? en_run : en_run + 4'h1);
    next_lim_run = drive.cur_limit ? lim_run + 16'h0001 : 16'h0000;
  end

  // registers only
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      en_run <= 4'h0;
      lim_run <= 16'h0000;
    end else begin
      en_run <= next_en_run;
      lim_run <= next_lim_run;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // one-cycle input spike while running
  sequence s_ov_blip;
    drive.pass_on && fault_oe_n && !sense.in_ov ##1 sense.in_ov ##1 !sense.in_ov;
  endsequence

  // enable steadily low; older pulses have passed the synchroniser
  sequence s_en_steady;
    (!enable_n) [*6];
  endsequence

  // overcurrent shutdown seen at the pins while enabled
  sequence s_ocp_trip;
    $fell(drive.cur_limit) && !drive.pass_on && en_run > 4'h8;
  endsequence

  AST_DISABLE_OFF: assert property (enable_n [*5] |-> !drive.pass_on && fault_oe_n)
    else $error("switch on or fault driven while disabled");
  AST_OV_CLAMP: assert property (sense.in_ov [*5] |-> !drive.pass_on || drive.out_clamp)
    else $error("switch on without clamp during overvoltage");
  AST_OV_BLIP: assert property (s_ov_blip |-> fault_oe_n [*6])
    else $error("short overvoltage spike raised a fault");
  AST_TRIP_FAULT: assert property (en_run > 4'h8 && $fell(drive.pass_on) |-> !fault_oe_n)
    else $error("protection shutdown without fault");
  AST_SOFT_STOP: assert property ($rose(drive.soft_stop) && en_run > 4'h8 |->
    (!drive.pass_on && !fault_oe_n) [*3])
    else $error("soft stop without switch off and fault");
  AST_OCP_BLANK: assert property (s_ocp_trip |-> lim_run >= OCP_BLANK_CYC - 1 &&
    lim_run <= OCP_BLANK_CYC + 1)
    else $error("overcurrent trip not at blanking end");
  AST_LATCH_OFF: assert property (latched_off |-> !drive.pass_on && !drive.soft_start)
    else $error("switch on while latched off");
  AST_LATCH_HOLD: assert property (s_en_steady ##0 latched_off |=> latched_off)
    else $error("latch released without enable toggle");

endmodule // cip_guard_fsm_assertions

// *** cip_host_model.sv ***
/*
  cip_host_model: host gpio on enable_n, pull-up on the fault line.
  Assumes requests from the bench change at the rising edge.
*/
`timescale 1ns/1ps
module cip_host_model (
  input wire logic clk_sys,
  input wire logic en_req,
  input wire logic en_float,
  input wire logic fault_out,
  input wire logic fault_oe_n,
  output logic enable_n,
  output logic fault_line
);
  logic drv_n = 1'b0;

  // gpio level moves just after the edge
  always @(posedge clk_sys) drv_n <= ~en_req;

  assign enable_n = en_float ? 1'b0 : drv_n;

  // released drain reads high through the pull-up
  assign fault_line = fault_oe_n ? 1'b1 : fault_out;
endmodule // cip_host_model

// *** charger_input_protection_fsm_tb.sv ***
/*
  charger_input_protection_fsm_tb: self-checking guard bench.
  Assumes short timing parameters; the host model drives enable_n.
*/
`timescale 1ns/1ps
module charger_input_protection_fsm_tb;
  import cip_pkg::*;
  localparam int OVB = 4;
  localparam int OVR = 6;
  localparam int OCB = 8;
  localparam int OCR = 8;
  localparam int PGD = 8;
  // trips up to and including the latching one, as the design counts them
  localparam int FAULT_LIMIT = CIP_FAULT_LIMIT;
  localparam cip_sense_s SAFE = 6'h05;
  localparam cip_sense_s OV = 6'h25;
  localparam cip_sense_s OC = 6'h15;
  localparam cip_sense_s HOT = 6'h06;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic en_req = 1'b1;
  logic en_float = 1'b0;
  cip_sense_s sense = SAFE;
  cip_drive_s drive;
  logic fault_out;
  logic fault_oe_n;
  logic latched_off;
  logic enable_n;
  logic fault_line;
  logic any_on;
  logic [15:0] seed = 16'h0050;
  int failures = 0;
  int check_count = 0;

  // free-running clock
  always #4 clk_sys = ~clk_sys;

  cip_guard_fsm #(.OVP_BLANK_CYC(OVB), .OVP_RESTART_CYC(OVR), .OCP_BLANK_CYC(OCB),
    .OCP_REC_CYC(OCR), .PGOOD_CYC(PGD), .SOFT_START_CYC(3), .SOFT_STOP_CYC(3)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .enable_n(enable_n), .sense(sense), .drive(drive),
    .fault_out(fault_out), .fault_oe_n(fault_oe_n), .latched_off(latched_off));

  cip_host_model i_host (.clk_sys(clk_sys), .en_req(en_req), .en_float(en_float),
    .fault_out(fault_out), .fault_oe_n(fault_oe_n), .enable_n(enable_n),
    .fault_line(fault_line));

  //////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] xs(input logic [15:0] v);
    logic [15:0] x;
    x = v ^ (v << 7);
    x = x ^ (x >> 9);
    return x ^ (x << 8);
  endfunction

  // switch state expected once the inputs have settled
  function automatic logic exp_on(input cip_sense_s s, input logic en_n);
    return !en_n && !s.in_ov && !s.in_oc && !s.bat_ov && !s.die_hot;
  endfunction

  function automatic logic probe(input int sel);
    case (sel)
      0: return drive.pass_on;
      1: return latched_off;
      2: return drive.out_clamp;
      default: return drive.cur_limit;
    endcase
  endfunction

  task automatic stop_test();
    if (failures == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %b seen %b", nm, exp, got);
    end
  endtask

  // bounded wait on an output, then compare
  task automatic await(input string nm, input int sel, input logic v, input int lim);
    int n;
    n = 0;
    #1;
    while (probe(sel) !== v && n < lim) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(nm, probe(sel), v);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic put(input cip_sense_s s);
    @(posedge clk_sys);
    sense <= s;
  endtask

  // watchdog well past the expected run
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    stop_test();
  end

  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    cyc(PGD - 2);
    chk("pass_on", drive.pass_on, 1'b0);
    await("pass_on", 0, 1'b1, 10);
    chk("fault", fault_line, 1'b1);
    // spikes shorter than blanking, random lengths
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      put(OV);
      repeat (i == 0 ? 0 : seed[0]) @(posedge clk_sys);
      put(SAFE);
      cyc(8);
      chk("pass_on", drive.pass_on, exp_on(sense, enable_n));
      chk("fault", fault_line, 1'b1);
      put(OC);
      await("cur_limit", 3, 1'b1, 6);
      cyc(seed[1]);
      put(SAFE);
      cyc(8);
      chk("pass_on", drive.pass_on, 1'b1);
      chk("fault", fault_line, 1'b1);
    end
    put(OV);
    await("out_clamp", 2, 1'b1, 5);
    await("pass_on", 0, 1'b0, OVB + 6);
    chk("fault", fault_line, 1'b0);
    put(SAFE);
    cyc(OVR);
    chk("pass_on", drive.pass_on, 1'b0);
    await("pass_on", 0, 1'b1, 8);
    chk("soft_start", drive.soft_start, 1'b1);
    // repeated overcurrent trips up to the latch
    for (int i = 1; i <= FAULT_LIMIT; i++) begin
      put(OC);
      await("pass_on", 0, 1'b0, OCB + 6);
      chk("soft_stop", drive.soft_stop, 1'b1);
      chk("fault", fault_line, 1'b0);
      put(SAFE);
      if (i < FAULT_LIMIT) begin
        cyc(OCR - 3);
        chk("pass_on", drive.pass_on, 1'b0);
        await("pass_on", 0, 1'b1, 8);
        chk("latched_off", latched_off, 1'b0);
      end
    end
    await("latched_off", 1, 1'b1, 4);
    cyc(OCR + 4);
    chk("pass_on", drive.pass_on, 1'b0);
    put(HOT);
    en_req <= 1'b0;
    cyc(8);
    chk("pass_on", drive.pass_on, 1'b0);
    chk("fault", fault_line, 1'b1);
    put(SAFE);
    en_req <= 1'b1;
    await("pass_on", 0, 1'b1, PGD + 12);
    chk("latched_off", latched_off, 1'b0);
    // battery trips through the hysteresis band
    for (int i = 1; i <= FAULT_LIMIT; i++) begin
      put(6'h09);
      await("pass_on", 0, 1'b0, 6);
      chk("soft_stop", drive.soft_stop, 1'b1);
      chk("fault", fault_line, 1'b0);
      put(6'h01);
      cyc(5);
      chk("pass_on", drive.pass_on, 1'b0);
      put(SAFE);
      if (i < FAULT_LIMIT) begin
        await("pass_on", 0, 1'b1, 8);
        chk("latched_off", latched_off, 1'b0);
      end
    end
    await("latched_off", 1, 1'b1, 4);
    @(posedge clk_sys);
    en_req <= 1'b0;
    cyc(8);
    @(posedge clk_sys);
    en_float <= 1'b1;
    await("pass_on", 0, 1'b1, PGD + 12);
    chk("latched_off", latched_off, 1'b0);
    put(HOT);
    await("pass_on", 0, 1'b0, 6);
    chk("fault", fault_line, 1'b0);
    put(6'h04);
    cyc(5);
    chk("pass_on", drive.pass_on, 1'b0);
    put(SAFE);
    await("pass_on", 0, 1'b1, 8);
    chk("fault", fault_line, 1'b1);
    // power-up into an input already too high
    put(OV);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    chk("pass_on", drive.pass_on, 1'b0);
    chk("fault", fault_line, 1'b1);
    any_on = 1'b0;
    repeat (PGD + 12) begin
      cyc(1);
      any_on = any_on | drive.pass_on;
    end
    chk("pass_on", any_on, 1'b0);
    chk("fault", fault_line, 1'b0);
    stop_test();
  end
endmodule // charger_input_protection_fsm_tb

bind cip_guard_fsm cip_guard_fsm_assertions #(.OCP_BLANK_CYC(OCP_BLANK_CYC)) i_chk (
  .clk_sys(clk_sys), .rst(rst), .enable_n(enable_n), .sense(sense), .drive(drive),
  .fault_out(fault_out), .fault_oe_n(fault_oe_n), .latched_off(latched_off));
